/* core/fpe_pkg.sv */
package fpe_pkg;

	// ---------------------------------------------------------------
	// Register map (byte addresses on the AXI4-Lite slave)
	// ---------------------------------------------------------------
	localparam logic [15:0] CTRL_ADDR    = 16'hFE08;
	localparam logic [15:0] PROT_ADDR    = 16'hFFF0;
	localparam logic [15:0] STAT_ADDR    = 16'hFE10;
	localparam logic [15:0] ARR_BASE     = 16'h7800;
	localparam logic [15:0] ARR_LAST     = 16'h7FEF;
	localparam logic [15:0] VEC_BASE     = 16'hFFF0;
	localparam int          ARR_BYTES    = 2048;
	localparam int          VEC_BYTES    = 16;

	// ---------------------------------------------------------------
	// Control register fields
	// ---------------------------------------------------------------
	localparam int          B_PGM        = 0;
	localparam int          B_ERASE      = 1;
	localparam int          B_MARGIN     = 2;
	localparam int          B_HIGH_VOLTAGE_ENABLE       = 3;
	localparam int          B_BLK_LO     = 4;
	localparam int          B_BLK_HI     = 5;
	localparam int          B_FDIV       = 6;
	localparam logic [7:0]  CTRL_RST     = 8'h00;
	localparam logic [7:0]  CTRL_MASK    = 8'h7F;
	localparam logic [7:0]  ERASED_BYTE  = 8'h00;

	// Erase size codes
	localparam logic [1:0]  SZ_FULL      = 2'h0;
	localparam logic [1:0]  SZ_HALF      = 2'h1;
	localparam logic [1:0]  SZ_8ROW      = 2'h2;
	localparam logic [1:0]  SZ_ROW       = 2'h3;

	// Protection range starts per protect bit 0..3
	localparam logic [15:0] PROT_START0  = 16'h7800;
	localparam logic [15:0] PROT_START1  = 16'h7880;
	localparam logic [15:0] PROT_START2  = 16'h7900;
	localparam logic [15:0] PROT_START3  = 16'h7A00;

	// Margin read stretch
	localparam logic [3:0]  MARGIN_WAIT  = 4'h8;

	// AXI responses
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic       fdiv;
		logic [1:0] blk;
		logic       high_voltage_enable;
		logic       margin;
		logic       erase;
		logic       program_select;
	} fpe_ctrl_s;

	typedef enum logic [3:0] {
		SEQ_IDLE = 4'b0001,
		SEQ_PROT = 4'b0010,
		SEQ_ADDR = 4'b0100,
		SEQ_ARM  = 4'b1000
	} fpe_seq_e;

endpackage : fpe_pkg

/* core/fpe_ctrl.sv */
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
//
// Overview of operation
// R1 - Erased cells read 0, programmed cells read 1.
// R2 - Array holds 2032 user bytes, 14 vector bytes, one protect byte; the code has 15 vector bytes beside the protect byte at FFF0.
// R3 - User space is rows of eight bytes, row 0 to row 253.
// R4 - Programming writes one byte per operation.
// R5 - Erase acts on blocks, smallest block one eight-byte row.
// R6 - High-voltage enable sets only with program/erase selected and sequence done.
// R7 - High-voltage enable bit runs the pump and array high voltage.
// R8 - Margin-read set while high voltage on is refused, stays 0.
// R9 - Erase-select and program-select are never both set.
// R10 - Pump clock is bus clock, halved when divide-select is 1.
// R11 - Software only programs/erases with bus clock at least 2 MHz.
// R12 - Software follows the ordered erase sequence with waits.
// R13 - Sequence steps in order, unrelated accesses between them tolerated.
// R14 - Block-size bits pick full, half, eight rows, or one row.
// R15 - Erase target address latched; only block-relevant bits used.
// R16 - Software erases a row after eight programs on it.
// R17 - Reading the protect byte latches it for the next operation.
// R18 - Target overlapping protected range clears program/erase select.
// R19 - Margin-mode array reads are stretched by eight cycles.
// R20 - Control bit layout: divider 6, size 5:4, hv/margin/erase/prog 3:0.
//
module fpe_ctrl (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        srst_i,
	// AXI4-Lite write
	input  wire logic [15:0] s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	// AXI4-Lite read
	input  wire logic [15:0] s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// Pump
	output logic             pump_clk_o,
	output logic             high_voltage_o
);

	// ---------------------------------------------------------------
	// Storage and control state
	// ---------------------------------------------------------------
	logic [7:0]         arr_mem [fpe_pkg::ARR_BYTES];  // R2 R3
	logic [7:0]         vec_mem [fpe_pkg::VEC_BYTES];  // R2
	fpe_pkg::fpe_ctrl_s ctrl_ff;
	fpe_pkg::fpe_seq_e  seq_ff;
	logic [7:0]         prot_ff;
	logic [15:0]        tgt_ff;
	logic [7:0]         pdata_ff;
	logic               pump_div_ff;
	logic               aw_ff;
	logic               w_ff;
	logic [15:0]        awaddr_ff;
	logic [31:0]        wdata_ff;
	logic               wstb_ff;
	logic [3:0]         rwait_ff;
	logic               rbusy_ff;
	logic [15:0]        raddr_ff;

	logic               wr_go;
	logic               rd_go;
	logic               in_arr;
	logic               in_vec;
	logic               r_arr;
	logic               r_vec;
	logic [15:0]        blk_mask;
	logic [15:0]        blk_lo;
	logic [15:0]        blk_hi;
	logic [15:0]        prot_lo;
	logic               prot_hit;
	logic [7:0]         nxt_rbyte;

	// ---------------------------------------------------------------
	// Write channel: take address and data in either order
	// ---------------------------------------------------------------
	assign s_axi_awready_o = !aw_ff && !s_axi_bvalid_o;
	assign s_axi_wready_o  = !w_ff && !s_axi_bvalid_o;
	assign wr_go           = aw_ff && w_ff && !s_axi_bvalid_o;

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			aw_ff     <= 1'b0;
			w_ff      <= 1'b0;
			awaddr_ff <= 16'h0000;
			wdata_ff  <= 32'h00000000;
			wstb_ff   <= 1'b0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_ff     <= 1'b1;
				awaddr_ff <= s_axi_awaddr_i;
			end else if (wr_go) begin
				aw_ff <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_ff     <= 1'b1;
				wdata_ff <= s_axi_wdata_i;
				wstb_ff  <= s_axi_wstrb_i[0];
			end else if (wr_go) begin
				w_ff <= 1'b0;
			end
		end
	end

	// Write response, one cycle after both halves are in
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= fpe_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= (in_arr || in_vec || awaddr_ff == fpe_pkg::CTRL_ADDR)
				? fpe_pkg::RESP_OKAY : fpe_pkg::RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	assign in_arr  = awaddr_ff >= fpe_pkg::ARR_BASE && awaddr_ff <= fpe_pkg::ARR_LAST;
	assign in_vec  = awaddr_ff >= fpe_pkg::VEC_BASE;
	assign r_arr   = raddr_ff >= fpe_pkg::ARR_BASE && raddr_ff <= fpe_pkg::ARR_LAST;
	assign r_vec   = raddr_ff >= fpe_pkg::VEC_BASE;

	// Erase extent mask: cleared bits are the ones inside the block
	always_comb begin
		unique case (ctrl_ff.blk)  // R14
			fpe_pkg::SZ_FULL: blk_mask = 16'hF800;
			fpe_pkg::SZ_HALF: blk_mask = 16'hFC00;
			fpe_pkg::SZ_8ROW: blk_mask = 16'hFFC0;
			fpe_pkg::SZ_ROW:  blk_mask = 16'hFFF8;  // R5
		endcase
	end
	assign blk_lo = tgt_ff & blk_mask;  // R15
	assign blk_hi = blk_lo | ~blk_mask;

	// Lowest protected address; the vector page is protected by any bit
	always_comb begin
		if (prot_ff[0])      prot_lo = fpe_pkg::PROT_START0;
		else if (prot_ff[1]) prot_lo = fpe_pkg::PROT_START1;
		else if (prot_ff[2]) prot_lo = fpe_pkg::PROT_START2;
		else                 prot_lo = fpe_pkg::PROT_START3;
	end
	// Vector page overlap only matters for targets up there
	assign prot_hit = (prot_ff[3:0] != 4'h0) &&
		(ctrl_ff.erase ? (blk_hi >= prot_lo || tgt_ff >= fpe_pkg::VEC_BASE)
		               : (tgt_ff >= prot_lo));

	// ---------------------------------------------------------------
	// Sequence tracker: IDLE advances once a select is set, later steps only on the access they wait for
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			seq_ff   <= fpe_pkg::SEQ_IDLE;
			prot_ff  <= 8'h00;
			tgt_ff   <= 16'h0000;
			pdata_ff <= 8'h00;
		end else if (!ctrl_ff.program_select && !ctrl_ff.erase) begin
			seq_ff <= fpe_pkg::SEQ_IDLE;
		end else begin
			unique case (seq_ff)
				fpe_pkg::SEQ_IDLE: seq_ff <= fpe_pkg::SEQ_PROT;
				fpe_pkg::SEQ_PROT: begin
					if (rd_go && s_axi_araddr_i == fpe_pkg::PROT_ADDR) begin
						prot_ff <= vec_mem[0];  // R17
						seq_ff  <= fpe_pkg::SEQ_ADDR;
					end
				end
				fpe_pkg::SEQ_ADDR: begin
					if (wr_go && wstb_ff && (in_arr || in_vec)) begin  // R13
						tgt_ff   <= awaddr_ff;  // R15
						pdata_ff <= wdata_ff[7:0];
						seq_ff   <= fpe_pkg::SEQ_ARM;
					end
				end
				fpe_pkg::SEQ_ARM: seq_ff <= fpe_pkg::SEQ_ARM;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Control register with interlocks
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ctrl_ff <= fpe_pkg::fpe_ctrl_s'(fpe_pkg::CTRL_RST[6:0]);  // R20
		end else if (seq_ff == fpe_pkg::SEQ_ARM && prot_hit) begin
			ctrl_ff.program_select   <= 1'b0;  // R18
			ctrl_ff.erase <= 1'b0;  // R18
			ctrl_ff.high_voltage_enable  <= 1'b0;
		end else if (wr_go && wstb_ff && awaddr_ff == fpe_pkg::CTRL_ADDR) begin
			ctrl_ff.fdiv  <= wdata_ff[fpe_pkg::B_FDIV];
			ctrl_ff.blk   <= wdata_ff[fpe_pkg::B_BLK_HI:fpe_pkg::B_BLK_LO];
			// Erase wins a simultaneous request unless program is already set, then both clear, so both never stand
			ctrl_ff.erase <= wdata_ff[fpe_pkg::B_ERASE] &&
				!(ctrl_ff.program_select && wdata_ff[fpe_pkg::B_PGM]);  // R9
			ctrl_ff.program_select   <= wdata_ff[fpe_pkg::B_PGM] && !wdata_ff[fpe_pkg::B_ERASE] &&
				!ctrl_ff.erase;  // R9
			ctrl_ff.margin <= wdata_ff[fpe_pkg::B_MARGIN] && !ctrl_ff.high_voltage_enable &&
				!wdata_ff[fpe_pkg::B_HIGH_VOLTAGE_ENABLE];  // R8
			ctrl_ff.high_voltage_enable  <= wdata_ff[fpe_pkg::B_HIGH_VOLTAGE_ENABLE] && (ctrl_ff.program_select || ctrl_ff.erase) &&
				seq_ff == fpe_pkg::SEQ_ARM && !prot_hit;  // R6
		end
	end

	// ---------------------------------------------------------------
	// High-voltage action on the array, on the enable's rising edge
	// ---------------------------------------------------------------
	logic hv_d_ff;
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			hv_d_ff <= 1'b0;
		end else begin
			hv_d_ff <= ctrl_ff.high_voltage_enable;
		end
	end

	// One generate loop covers every array byte; erase clears, program ORs in ones
	for (genvar gi = 0; gi < fpe_pkg::ARR_BYTES; gi++) begin : g_arr
		localparam logic [15:0] A = fpe_pkg::ARR_BASE + 16'(gi);
		always_ff @(posedge sys_clk_i) begin
			if (srst_i) begin
				arr_mem[gi] <= fpe_pkg::ERASED_BYTE;
			end else if (ctrl_ff.high_voltage_enable && !hv_d_ff) begin
				if (ctrl_ff.erase && A >= blk_lo && A <= blk_hi) begin
					arr_mem[gi] <= fpe_pkg::ERASED_BYTE;  // R1 R5
				end else if (ctrl_ff.program_select && tgt_ff == A) begin
					arr_mem[gi] <= arr_mem[gi] | pdata_ff;  // R1 R4
				end
			end
		end
	end

	// Vector page: erased only by a block that holds the target, programmed bytewise
	for (genvar gv = 0; gv < fpe_pkg::VEC_BYTES; gv++) begin : g_vec
		localparam logic [15:0] A = fpe_pkg::VEC_BASE + 16'(gv);
		always_ff @(posedge sys_clk_i) begin
			if (srst_i) begin
				vec_mem[gv] <= fpe_pkg::ERASED_BYTE;
			end else if (ctrl_ff.high_voltage_enable && !hv_d_ff) begin
				if (ctrl_ff.erase && (tgt_ff & blk_mask) == (A & blk_mask)) begin
					vec_mem[gv] <= fpe_pkg::ERASED_BYTE;
				end else if (ctrl_ff.program_select && tgt_ff == A) begin
					vec_mem[gv] <= vec_mem[gv] | pdata_ff;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Charge pump clock and high-voltage drive
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			pump_div_ff <= 1'b0;
		end else if (ctrl_ff.high_voltage_enable) begin
			pump_div_ff <= !pump_div_ff;
		end else begin
			pump_div_ff <= 1'b0;
		end
	end
	// Undivided mode gates the bus clock; kept simple for a behavioural pump
	assign pump_clk_o     = ctrl_ff.high_voltage_enable &&
		(ctrl_ff.fdiv ? pump_div_ff : sys_clk_i);  // R10 R7
	assign high_voltage_o = ctrl_ff.high_voltage_enable;  // R7

	// ---------------------------------------------------------------
	// Read channel, stretched eight cycles for margin array reads
	// ---------------------------------------------------------------
	assign s_axi_arready_o = !rbusy_ff && !s_axi_rvalid_o;
	assign rd_go           = s_axi_arvalid_i && s_axi_arready_o;

	always_comb begin
		nxt_rbyte = 8'h00;
		if (raddr_ff == fpe_pkg::CTRL_ADDR) begin
			nxt_rbyte = 8'(ctrl_ff) & fpe_pkg::CTRL_MASK;  // R20
		end else if (raddr_ff == fpe_pkg::STAT_ADDR) begin
			nxt_rbyte = {4'h0, seq_ff};
		end else if (r_arr) begin
			nxt_rbyte = arr_mem[raddr_ff[10:0]];
		end else if (r_vec) begin
			nxt_rbyte = vec_mem[raddr_ff[3:0]];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			rbusy_ff       <= 1'b0;
			rwait_ff       <= 4'h0;
			raddr_ff       <= 16'h0000;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h00000000;
			s_axi_rresp_o  <= fpe_pkg::RESP_OKAY;
		end else if (rd_go) begin
			rbusy_ff <= 1'b1;
			raddr_ff <= s_axi_araddr_i;
			rwait_ff <= (ctrl_ff.margin && s_axi_araddr_i >= fpe_pkg::ARR_BASE &&
				s_axi_araddr_i <= fpe_pkg::ARR_LAST) ? fpe_pkg::MARGIN_WAIT : 4'h0;  // R19
		end else if (rbusy_ff && rwait_ff != 4'h0) begin
			rwait_ff <= rwait_ff - 4'h1;
		end else if (rbusy_ff) begin
			rbusy_ff       <= 1'b0;
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o  <= {24'h000000, nxt_rbyte};
			s_axi_rresp_o  <= (r_arr || r_vec || raddr_ff == fpe_pkg::CTRL_ADDR ||
				raddr_ff == fpe_pkg::STAT_ADDR) ? fpe_pkg::RESP_OKAY : fpe_pkg::RESP_SLVERR;
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

endmodule : fpe_ctrl

/* tb/fpe_chk.sv */
`timescale 1ns/1ps
module fpe_chk (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        srst_i,
	// Bus handshakes
	input  wire logic        s_axi_awvalid_i,
	input  wire logic        s_axi_awready_o,
	input  wire logic        s_axi_wvalid_i,
	input  wire logic        s_axi_wready_o,
	input  wire logic        s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [15:0] s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	input  wire logic        s_axi_arready_o,
	input  wire logic [31:0] s_axi_rdata_o,
	input  wire logic        s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// Pump
	input  wire logic        pump_clk_o,
	input  wire logic        high_voltage_o
);
	logic [15:0] rd_addr_ff;
	logic        ctrl_rd;

	// Address of the read in flight, to know when rdata is the control byte
	always_ff @(posedge sys_clk_i) begin
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			rd_addr_ff <= s_axi_araddr_i;
		end
	end
	assign ctrl_rd = s_axi_rvalid_o && (rd_addr_ff == fpe_pkg::CTRL_ADDR);

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);

	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	a_pump_quiet: assert property (!high_voltage_o |-> !pump_clk_o)
		else $error("pump clock runs with high voltage off");
	a_hv_by_write: assert property ($rose(high_voltage_o) |-> $rose(s_axi_bvalid_o))
		else $error("high voltage rose without a completed write");
	a_sel_excl: assert property (ctrl_rd |-> !(s_axi_rdata_o[0] && s_axi_rdata_o[1]))
		else $error("program and erase both set");
	a_margin_hv: assert property (ctrl_rd |-> !(s_axi_rdata_o[2] && s_axi_rdata_o[3]))
		else $error("margin set together with high voltage");
	a_ctrl_layout: assert property (ctrl_rd |->
		s_axi_rdata_o[31:7] == 25'h0 && s_axi_rdata_o[3] == high_voltage_o)
		else $error("control byte layout wrong");
	a_rd_latency: assert property (s_axi_arvalid_i && s_axi_arready_o |-> ##[2:10] s_axi_rvalid_o)
		else $error("read answer late");
	a_wr_latency: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
		&& s_axi_wready_o |-> ##2 s_axi_bvalid_o)
		else $error("write answer not two cycles after handshake");
	a_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
		else $error("write response dropped early");
	a_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> $stable(s_axi_rdata_o))
		else $error("read data changed before taken");

	c_hv_on: cover property ($rose(high_voltage_o));
	c_hv_off: cover property ($fell(high_voltage_o));
	c_erase_rd: cover property (ctrl_rd && s_axi_rdata_o[1]);
endmodule : fpe_chk

bind fpe_ctrl fpe_chk u_chk (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
	.s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
	.s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
	.s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
	.s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
	.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
	.pump_clk_o(pump_clk_o), .high_voltage_o(high_voltage_o));

/* tb/fpe_cpu.sv */
`timescale 1ns/1ps
module fpe_cpu (
	// Clock
	input  wire logic        clk_i,
	// Write channels
	output logic [15:0]      awaddr_o,
	output logic             awvalid_o,
	input  wire logic        awready_i,
	output logic [31:0]      wdata_o,
	output logic [3:0]       wstrb_o,
	output logic             wvalid_o,
	input  wire logic        wready_i,
	input  wire logic [1:0]  bresp_i,
	input  wire logic        bvalid_i,
	output logic             bready_o,
	// Read channels
	output logic [15:0]      araddr_o,
	output logic             arvalid_o,
	input  wire logic        arready_i,
	input  wire logic [31:0] rdata_i,
	input  wire logic [1:0]  rresp_i,
	input  wire logic        rvalid_i,
	output logic             rready_o
);
	// Bus idle at time zero
	initial begin
		{awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
		{araddr_o, arvalid_o, rready_o} = '0;
	end

	// Byte write; each half released once taken, the bench watchdog ends a hang
	task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] resp);
		@(posedge clk_i);
		awaddr_o <= a;
		wdata_o <= {24'h000000, d};
		wstrb_o <= 4'hF;
		awvalid_o <= 1'b1;
		wvalid_o <= 1'b1;
		bready_o <= 1'b1;
		do begin
			@(posedge clk_i);
			if (awready_i) awvalid_o <= 1'b0;
			if (wready_i) wvalid_o <= 1'b0;
		end while (!bvalid_i);
		resp = bresp_i;
		bready_o <= 1'b0;
	endtask : wr

	// Read; n returns the cycles until the answer
	task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] resp,
		output int n);
		n = 0;
		@(posedge clk_i);
		araddr_o <= a;
		arvalid_o <= 1'b1;
		rready_o <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			if (arready_i) arvalid_o <= 1'b0;
		end while (!rvalid_i);
		d = rdata_i;
		resp = rresp_i;
		rready_o <= 1'b0;
	endtask : rd
endmodule : fpe_cpu

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic        clk, srst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, pump, hv;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata, rdata, x;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	int          n_fail, num_checks, pump_edges, n0, n1;

	fpe_ctrl i_fpe_ctrl (.sys_clk_i(clk), .srst_i(srst), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .pump_clk_o(pump), .high_voltage_o(hv));
	fpe_cpu u_cpu (.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
		.wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
		.bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
		.arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
		.rvalid_i(rvalid), .rready_o(rready));

	// 100 MHz bus clock, well above the pump minimum
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge pump) pump_edges++;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic wc(input logic [7:0] v);
		u_cpu.wr(fpe_pkg::CTRL_ADDR, v, r);
	endtask : wc
	task automatic rb(input logic [15:0] a, input logic [7:0] e);
		u_cpu.rd(a, x, r, n0);
		chk("read", {24'h0, e}, x);
	endtask : rb
	// Program one byte; f carries the divide bit, pump counted while on
	task automatic prog(input logic [15:0] a, input logic [7:0] v, input logic [7:0] f);
		wc(f | 8'h01);
		u_cpu.rd(fpe_pkg::STAT_ADDR, x, r, n0);
		chk("state", 32'h2, x);
		u_cpu.rd(fpe_pkg::PROT_ADDR, x, r, n0);
		u_cpu.wr(a, v, r);
		wc(f | 8'h09);
		chk("hv", 1, hv);
		@(negedge clk) pump_edges = 0;
		repeat (20) @(negedge clk);
		chk("pump", f[6] ? 10 : 20, pump_edges);
		wc(f | 8'h01);
		wc(8'h00);
		chk("hv_off", 0, hv);
	endtask : prog
	// Erase one block, then byte g must read 00 and byte k must read e
	task automatic erase(input logic [1:0] c, input logic [15:0] a, input logic [15:0] g,
		input logic [15:0] k, input logic [7:0] e);
		wc({2'b00, c, 4'h2});
		u_cpu.rd(fpe_pkg::PROT_ADDR, x, r, n0);
		u_cpu.wr(a, 8'h5A, r);
		wc({2'b00, c, 4'hA});
		wc({2'b00, c, 4'h2});
		wc(8'h00);
		rb(g, 8'h00);
		rb(k, e);
	endtask : erase
	task automatic finish_test;
		if (n_fail == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test

	// Watchdog, about ten times the expected run length
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		finish_test();
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		n_fail = 0;
		num_checks = 0;
		srst = 1'b1;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		u_cpu.rd(fpe_pkg::CTRL_ADDR, x, r, n0);
		chk("ctrl_reset", 0, x);
		wc(8'hFF);
		u_cpu.rd(fpe_pkg::CTRL_ADDR, x, r, n0);
		chk("ctrl_all", 32'h72, x);
		wc(8'h00);
		wc(8'h01);
		wc(8'h09);
		chk("hv_early", 0, hv);
		wc(8'h00);
		u_cpu.rd(16'h0100, x, r, n0);
		chk("rd_resp", 2, r);
		u_cpu.wr(16'h0100, 8'h11, r);
		chk("wr_resp", 2, r);
		// At most one program per row before erase
		prog(16'h7808, 8'h3C, 8'h00);
		prog(16'h7810, 8'hA5, 8'h40);
		prog(16'h7838, 8'hC3, 8'h00);
		prog(16'h7840, 8'h81, 8'h40);
		rb(16'h7811, 8'h00);
		rb(16'h7810, 8'hA5);
		n1 = n0;
		wc(8'h04);
		rb(16'h7810, 8'hA5);
		chk("margin_wait", n1 + 8, n0);
		wc(8'h00);
		erase(2'h3, 16'h7810, 16'h7810, 16'h7808, 8'h3C);
		erase(2'h2, 16'h7870, 16'h7840, 16'h7838, 8'hC3);
		prog(16'h7C00, 8'h77, 8'h00);
		erase(2'h1, 16'h7C00, 16'h7C00, 16'h7808, 8'h3C);
		erase(2'h0, 16'h78F0, 16'h7808, 16'h7838, 8'h00);
		// Lock 7A00 upward, then a program there must be stopped
		prog(16'hFFF0, 8'h08, 8'h00);
		wc(8'h01);
		u_cpu.rd(fpe_pkg::PROT_ADDR, x, r, n0);
		chk("prot", 8, x);
		u_cpu.wr(16'h7A10, 8'hFF, r);
		u_cpu.rd(fpe_pkg::CTRL_ADDR, x, r, n0);
		chk("ctrl_locked", 0, x);
		wc(8'h09);
		chk("hv_locked", 0, hv);
		rb(16'h7A10, 8'h00);
		finish_test();
	end
endmodule : testbench
